// ===== rtl/capture_compare_timer_core.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "cct_consts.svh"
module capture_compare_timer_core #(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer tick and chip mode
    input wire logic timer_tick,
    input wire logic special_mode,
    // Channel pins
    input wire logic [NUM_CH-1:0] channel_pin_in,
    output logic [NUM_CH-1:0] channel_pin_out,
    output logic [NUM_CH-1:0] channel_pin_oe
);
    import cct_pkg::*;

    logic [NUM_CH-1:0] dir_sel_r;
    logic [NUM_CH-1:0] ovf_toggle_r;
    logic [7:0] pin_action_r;
    logic [7:0] edge_sel_r;
    logic timer_on_r;
    logic fast_clear_r;
    logic [15:0] main_count_r;
    logic [15:0] chan_value_r [NUM_CH];
    logic [NUM_CH-1:0] chan_flag_r;
    logic wrap_flag_r;
    logic [31:0] prdata_r;
    logic wr_acc;
    logic rd_acc;
    logic acc;
    logic count_wr;
    logic count_acc;
    logic count_step;
    logic wrap;
    logic mapped;
    logic [31:0] rd_mux;
    logic [NUM_CH-1:0] capture;
    logic [NUM_CH-1:0] cmp_hit;
    logic [NUM_CH-1:0] force_hit;
    logic [NUM_CH-1:0] flag_set;
    logic [NUM_CH-1:0] flag_clr;
    chan_cfg_t cfg [NUM_CH];

    // Word address match against a register index
    function automatic logic addr_is(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'b00, idx, 2'b00};
    endfunction : addr_is

    // Match against the channel value register of a given channel
    function automatic logic addr_is_value(input logic [11:0] a, input int ch);
        return addr_is(a, 8'(`IDX_CHAN_VALUE0 + ch));
    endfunction : addr_is_value

    // Bus phases: writes and read side effects happen in the access phase only
    assign acc = psel && penable;
    assign wr_acc = acc && pwrite;
    assign rd_acc = acc && !pwrite;
    assign count_acc = acc && addr_is(paddr, `IDX_MAIN_COUNT);
    assign count_wr = wr_acc && addr_is(paddr, `IDX_MAIN_COUNT) && special_mode;
    assign count_step = timer_on_r && timer_tick;
    assign wrap = count_step && (main_count_r == `COUNT_ALL_ONES);

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata = prdata_r;

    // Read mux; reserved bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b1;
        if (addr_is(paddr, `IDX_DIR_SEL)) begin
            rd_mux[NUM_CH-1:0] = dir_sel_r;
        end else if (addr_is(paddr, `IDX_FORCE)) begin
            rd_mux = 32'h0000_0000;
        end else if (addr_is(paddr, `IDX_MAIN_COUNT)) begin
            rd_mux[15:0] = main_count_r;
        end else if (addr_is(paddr, `IDX_SYS_CTRL_ONE)) begin
            rd_mux[`BIT_TIMER_ON] = timer_on_r;
            rd_mux[`BIT_FAST_FLAG_CLEAR] = fast_clear_r;
        end else if (addr_is(paddr, `IDX_OVF_TOGGLE)) begin
            rd_mux[NUM_CH-1:0] = ovf_toggle_r;
        end else if (addr_is(paddr, `IDX_PIN_ACTION)) begin
            rd_mux[7:0] = pin_action_r;
        end else if (addr_is(paddr, `IDX_EDGE_SEL)) begin
            rd_mux[7:0] = edge_sel_r;
        end else if (addr_is(paddr, `IDX_CHAN_FLAGS)) begin
            rd_mux[NUM_CH-1:0] = chan_flag_r;
        end else if (addr_is(paddr, `IDX_WRAP_FLAGS)) begin
            rd_mux[`BIT_WRAP_FLAG] = wrap_flag_r;
        end else begin
            mapped = 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                if (addr_is_value(paddr, i)) begin
                    rd_mux[15:0] = chan_value_r[i];
                    mapped = 1'b1;
                end
            end
        end
    end

    // Read data registered in the setup phase so it stands through access
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    // Control registers, all cleared at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_sel_r <= `RST_NIBBLE;
            ovf_toggle_r <= `RST_NIBBLE;
            pin_action_r <= `RST_REG8;
            edge_sel_r <= `RST_REG8;
            timer_on_r <= 1'b0;
            fast_clear_r <= 1'b0;
        end else if (wr_acc) begin
            if (addr_is(paddr, `IDX_DIR_SEL)) begin
                dir_sel_r <= pwdata[NUM_CH-1:0];
            end
            if (addr_is(paddr, `IDX_OVF_TOGGLE)) begin
                ovf_toggle_r <= pwdata[NUM_CH-1:0];
            end
            if (addr_is(paddr, `IDX_PIN_ACTION)) begin
                pin_action_r <= pwdata[7:0];
            end
            if (addr_is(paddr, `IDX_EDGE_SEL)) begin
                edge_sel_r <= pwdata[7:0];
            end
            if (addr_is(paddr, `IDX_SYS_CTRL_ONE)) begin
                timer_on_r <= pwdata[`BIT_TIMER_ON];
                fast_clear_r <= pwdata[`BIT_FAST_FLAG_CLEAR];
            end
        end
    end

    // Main counter; a write does not realign the external tick, so the first
    // period after it may be short
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_count_r <= `RST_MAIN_COUNT;
        end else if (count_wr) begin
            main_count_r <= pwdata[15:0];
        end else if (count_step) begin
            main_count_r <= main_count_r + 16'h0001;
        end
    end

    // Wrap flag; a wrap in the clearing cycle keeps the flag set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrap_flag_r <= 1'b0;
        end else if (wrap) begin
            wrap_flag_r <= 1'b1;
        end else if (fast_clear_r && count_acc) begin
            wrap_flag_r <= 1'b0;
        end else if (wr_acc && addr_is(paddr, `IDX_WRAP_FLAGS) && pwdata[`BIT_WRAP_FLAG]) begin
            wrap_flag_r <= 1'b0;
        end
    end

    // Per-channel configuration, events and pin logic
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign cfg[g].dir = dir_sel_r[g];
        assign cfg[g].ovf_toggle = ovf_toggle_r[g];
        assign cfg[g].pin_action = pin_action_t'(pin_action_r[2*g+1 -: 2]);
        assign cfg[g].edge_sel = edge_sel_t'(edge_sel_r[2*g+1 -: 2]);

        assign cmp_hit[g] = count_step && dir_sel_r[g] && (main_count_r == chan_value_r[g]);
        assign force_hit[g] = wr_acc && addr_is(paddr, `IDX_FORCE) && pwdata[g];
        // A forced action never sets the flag and masks a coincident compare
        assign flag_set[g] = capture[g] || (cmp_hit[g] && !force_hit[g]);
        assign flag_clr[g] = (wr_acc && addr_is(paddr, `IDX_CHAN_FLAGS) && pwdata[g])
            || (fast_clear_r && !dir_sel_r[g] && rd_acc && addr_is_value(paddr, g))
            || (fast_clear_r && dir_sel_r[g] && wr_acc && addr_is_value(paddr, g));

        capture_edge_detect u_edge (
            .clk(clk),
            .rst_n(rst_n),
            .cfg(cfg[g]),
            .timer_on(timer_on_r),
            .pin_in(channel_pin_in[g]),
            .capture(capture[g])
        );

        compare_pin_logic u_pin (
            .clk(clk),
            .rst_n(rst_n),
            .cfg(cfg[g]),
            .wrap(wrap),
            .force_hit(force_hit[g]),
            .cmp_hit(cmp_hit[g]),
            .oc_out(channel_pin_out[g]),
            .oc_oe(channel_pin_oe[g])
        );

        // Value register: capture copies the count, software sets compare value
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                chan_value_r[g] <= `RST_MAIN_COUNT;
            end else if (capture[g]) begin
                chan_value_r[g] <= main_count_r;
            end else if (wr_acc && dir_sel_r[g] && addr_is_value(paddr, g)) begin
                chan_value_r[g] <= pwdata[15:0];
            end
        end

        // Event flag; a set in the clearing cycle wins
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                chan_flag_r[g] <= 1'b0;
            end else if (flag_set[g]) begin
                chan_flag_r[g] <= 1'b1;
            end else if (flag_clr[g]) begin
                chan_flag_r[g] <= 1'b0;
            end
        end
    end

    property p_count_inc;
        @(posedge clk) disable iff (!rst_n)
        (count_step && !count_wr) |=> main_count_r == $past(main_count_r) + 16'h0001;
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("count did not advance on tick");

    property p_count_ro_normal;
        @(posedge clk) disable iff (!rst_n)
        (wr_acc && addr_is(paddr, `IDX_MAIN_COUNT) && !special_mode && !count_step) |=> $stable(main_count_r);
    endproperty
    a_count_ro_normal: assert property (p_count_ro_normal) else $error("count written outside special mode");

    property p_timer_off_hold;
        @(posedge clk) disable iff (!rst_n)
        (!timer_on_r && !count_wr) [*2] |=> $stable(main_count_r);
    endproperty
    a_timer_off_hold: assert property (p_timer_off_hold) else $error("count moved while timer off");

    property p_wrap_flag_set;
        @(posedge clk) disable iff (!rst_n)
        wrap |=> wrap_flag_r && main_count_r == 16'h0000 || $past(count_wr);
    endproperty
    a_wrap_flag_set: assert property (p_wrap_flag_set) else $error("wrap flag not set on wrap");

    property p_fast_clear_count;
        @(posedge clk) disable iff (!rst_n)
        (fast_clear_r && count_acc && !wrap) |=> !wrap_flag_r;
    endproperty
    a_fast_clear_count: assert property (p_fast_clear_count) else $error("count access kept wrap flag");

    property p_ovf_toggle;
        @(posedge clk) disable iff (!rst_n)
        (wrap && dir_sel_r[0] && ovf_toggle_r[0]) |=> channel_pin_out[0] != $past(channel_pin_out[0]);
    endproperty
    a_ovf_toggle: assert property (p_ovf_toggle) else $error("compare line not inverted on wrap");

    property p_capture_no_drive;
        @(posedge clk) disable iff (!rst_n)
        !dir_sel_r[0] |=> $stable(channel_pin_out[0]) && !channel_pin_oe[0] || dir_sel_r[0];
    endproperty
    a_capture_no_drive: assert property (p_capture_no_drive) else $error("capture channel pin changed");

    property p_pin_oe;
        @(posedge clk) disable iff (!rst_n)
        channel_pin_oe[1] == (dir_sel_r[1] && pin_action_r[3:2] != 2'b00);
    endproperty
    a_pin_oe: assert property (p_pin_oe) else $error("pin enable does not follow pair");

    property p_capture_copy;
        @(posedge clk) disable iff (!rst_n)
        capture[1] |=> chan_value_r[1] == $past(main_count_r) && chan_flag_r[1];
    endproperty
    a_capture_copy: assert property (p_capture_copy) else $error("capture did not copy count and flag");

    property p_flag_w1c;
        @(posedge clk) disable iff (!rst_n)
        (wr_acc && addr_is(paddr, `IDX_CHAN_FLAGS) && pwdata[0] && !flag_set[0]) |=> !chan_flag_r[0];
    endproperty
    a_flag_w1c: assert property (p_flag_w1c) else $error("flag write one did not clear");

endmodule : capture_compare_timer_core

// ===== rtl/cct_consts.svh
`ifndef CCT_CONSTS_SVH
`define CCT_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define IDX_DIR_SEL 8'h20
`define IDX_FORCE 8'h21
`define IDX_MAIN_COUNT 8'h24
`define IDX_SYS_CTRL_ONE 8'h26
`define IDX_OVF_TOGGLE 8'h27
`define IDX_PIN_ACTION 8'h28
`define IDX_EDGE_SEL 8'h29
`define IDX_CHAN_FLAGS 8'h2C
`define IDX_WRAP_FLAGS 8'h2D
`define IDX_CHAN_VALUE0 8'h30

// Field positions
`define BIT_TIMER_ON 7
`define BIT_FAST_FLAG_CLEAR 4
`define BIT_WRAP_FLAG 7

// Reset values and counter limits
`define RST_MAIN_COUNT 16'h0000
`define RST_REG8 8'h00
`define RST_NIBBLE 4'h0
`define COUNT_ALL_ONES 16'hFFFF

`endif

// ===== rtl/cct_pkg.sv
package cct_pkg;

    // Pin action on a successful compare, encoded as mode/level pair
    typedef enum logic [1:0] {
        ACT_DISCONNECT,
        ACT_TOGGLE,
        ACT_DRIVE_LOW,
        ACT_DRIVE_HIGH
    } pin_action_t;

    // Capture edge choice, encoded as high/low select pair
    typedef enum logic [1:0] {
        EDGE_OFF,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_ANY
    } edge_sel_t;

    // Per-channel configuration travelling to the channel modules
    typedef struct packed {
        logic dir;
        logic ovf_toggle;
        pin_action_t pin_action;
        edge_sel_t edge_sel;
    } chan_cfg_t;

endpackage : cct_pkg

// ===== rtl/capture_edge_detect.sv
`timescale 1ns/1ps
module capture_edge_detect (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire cct_pkg::chan_cfg_t cfg,
    input wire logic timer_on,
    // Pin sample and event
    input wire logic pin_in,
    output logic capture
);
    import cct_pkg::*;

    logic pin_prev_r;

    // Previous pin level for edge detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= pin_in;
        end
    end

    // Edge qualified by select pair; output compare channels never capture
    always_comb begin
        capture = 1'b0;
        if (timer_on && !cfg.dir) begin
            unique case (cfg.edge_sel)
                EDGE_OFF: capture = 1'b0;
                EDGE_RISE: capture = pin_in && !pin_prev_r;
                EDGE_FALL: capture = !pin_in && pin_prev_r;
                EDGE_ANY: capture = pin_in != pin_prev_r;
            endcase
        end
    end

endmodule : capture_edge_detect

// ===== rtl/compare_pin_logic.sv
`timescale 1ns/1ps
module compare_pin_logic (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Configuration
    input wire cct_pkg::chan_cfg_t cfg,
    // Events
    input wire logic wrap,
    input wire logic force_hit,
    input wire logic cmp_hit,
    // Pin drive
    output logic oc_out,
    output logic oc_oe
);
    import cct_pkg::*;

    logic oc_r;

    // Compare output line; overflow toggle outranks a forced or real compare
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_r <= 1'b0;
        end else if (cfg.dir && cfg.ovf_toggle && wrap) begin
            oc_r <= !oc_r;
        end else if (cfg.dir && (force_hit || cmp_hit)) begin
            unique case (cfg.pin_action)
                ACT_DISCONNECT: oc_r <= oc_r;
                ACT_TOGGLE: oc_r <= !oc_r;
                ACT_DRIVE_LOW: oc_r <= 1'b0;
                ACT_DRIVE_HIGH: oc_r <= 1'b1;
            endcase
        end
    end

    assign oc_out = oc_r;
    // Pin becomes an output only for a connected output compare channel
    assign oc_oe = cfg.dir && (cfg.pin_action != ACT_DISCONNECT);

endmodule : compare_pin_logic

// ===== verification/pin_world.sv
`timescale 1ns/1ps
module pin_world (
    // Levels the outside world puts on each pin
    input wire logic [3:0] ext_level,
    // Design side of the pins
    input wire logic [3:0] pin_out,
    input wire logic [3:0] pin_oe,
    output logic [3:0] pin_in
);
    // Resolved wire: the design wins while it drives, else the outside level
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
        end
    end
endmodule : pin_world

// ===== verification/tb.sv
`timescale 1ns/1ps
`include "cct_consts.svh"
module tb;
    import cct_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic timer_tick = 1'b0;
    logic special_mode = 1'b0;
    logic [3:0] ext_level = 4'h0;
    logic [3:0] pin_in;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [31:0] rd;
    logic last_err;
    logic [7:0] rst_regs [5];
    pin_action_t acts [4];
    logic [3:0] act_out;
    int n_errors = 0;
    int check_count = 0;

    // Free-running bus clock, 25 ns period
    always #12.5 clk = ~clk;

    capture_compare_timer_core dut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_tick(timer_tick), .special_mode(special_mode),
        .channel_pin_in(pin_in), .channel_pin_out(pin_out), .channel_pin_oe(pin_oe)
    );

    // Outside world on the channel pins
    pin_world world (.ext_level(ext_level), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

    task close_out;
        $display("checks %0d, mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; entered just after a rising edge, leaves one idle cycle
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        k = 0;
        while (pready !== 1'b1 && k < 16) begin
            @(posedge clk);
            k++;
        end
        if (k == 16) begin
            n_errors++;
            $display("wrong value pready: expected 1, seen %b", pready);
            close_out();
        end else begin
            rd = prdata;
            last_err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask : apb

    task ticks(input int n);
        repeat (n) begin
            timer_tick <= 1'b1;
            @(posedge clk);
        end
        timer_tick <= 1'b0;
        @(posedge clk);
    endtask : ticks

    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    initial begin
        rst_regs = '{`IDX_MAIN_COUNT, `IDX_SYS_CTRL_ONE, `IDX_OVF_TOGGLE, `IDX_PIN_ACTION, `IDX_EDGE_SEL};
        acts = '{ACT_DRIVE_HIGH, ACT_TOGGLE, ACT_TOGGLE, ACT_DRIVE_LOW};
        act_out = 4'h5;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset state: stopped, disconnected, no capture
        foreach (rst_regs[i]) begin
            apb(1'b0, rst_regs[i], 32'h0);
            chk("reset reg", 32'h0, rd);
        end
        chk("oe after reset", 32'h0, {28'h0, pin_oe});
        $display("test reset done");

        // Count writes honoured only in special mode, always as one word
        apb(1'b1, `IDX_MAIN_COUNT, 32'h1111);
        apb(1'b0, `IDX_MAIN_COUNT, 32'h0);
        chk("count normal write", 32'h0, rd);
        special_mode <= 1'b1;
        apb(1'b1, `IDX_MAIN_COUNT, 32'h0100);
        apb(1'b0, `IDX_MAIN_COUNT, 32'h0);
        chk("count special write", 32'h0100, rd);
        ticks(3);
        apb(1'b0, `IDX_MAIN_COUNT, 32'h0);
        chk("count while off", 32'h0100, rd);
        apb(1'b1, `IDX_SYS_CTRL_ONE, 32'h80);
        ticks(5);
        apb(1'b0, `IDX_MAIN_COUNT, 32'h0);
        chk("count after ticks", 32'h0105, rd);
        $display("test counting done");

        // Channel 0 and 2 compare, 1 and 3 capture; overflow toggle on channels 0 and 1
        apb(1'b1, `IDX_DIR_SEL, 32'h5);
        apb(1'b1, `IDX_CHAN_VALUE0, 32'h8000);
        apb(1'b1, `IDX_CHAN_VALUE0 + 8'h02, 32'h8000);
        apb(1'b1, `IDX_PIN_ACTION, {30'h0, ACT_DRIVE_LOW});
        apb(1'b1, `IDX_OVF_TOGGLE, 32'h3);
        chk("oe ch0 driving", 32'h1, {31'h0, pin_oe[0]});
        apb(1'b1, `IDX_MAIN_COUNT, 32'hFFFE);
        ticks(2);
        idle(3);
        apb(1'b0, `IDX_MAIN_COUNT, 32'h0);
        chk("count wrapped", 32'h0, rd);
        apb(1'b0, `IDX_WRAP_FLAGS, 32'h0);
        chk("wrap flag set", 32'h80, rd);
        chk("ch0 toggled", 32'h1, {31'h0, pin_out[0]});
        chk("ch1 capture pin", 32'h0, {30'h0, pin_oe[1], pin_out[1]});
        apb(1'b1, `IDX_WRAP_FLAGS, 32'h80);
        apb(1'b0, `IDX_WRAP_FLAGS, 32'h0);
        chk("wrap flag cleared", 32'h0, rd);
        // Fast clear: a count read drops the wrap flag
        apb(1'b1, `IDX_SYS_CTRL_ONE, 32'h90);
        apb(1'b1, `IDX_MAIN_COUNT, 32'hFFFF);
        ticks(1);
        idle(3);
        apb(1'b0, `IDX_WRAP_FLAGS, 32'h0);
        chk("wrap flag again", 32'h80, rd);
        apb(1'b0, `IDX_MAIN_COUNT, 32'h0);
        apb(1'b0, `IDX_WRAP_FLAGS, 32'h0);
        chk("wrap fast clear", 32'h0, rd);
        chk("ch0 toggled back", 32'h0, {31'h0, pin_out[0]});
        $display("test wrap done");

        // Forced compare actions on channel 2, every pair code except disconnect
        foreach (acts[i]) begin
            apb(1'b1, `IDX_PIN_ACTION, {26'h0, acts[i], 2'h0, ACT_DRIVE_LOW});
            apb(1'b1, `IDX_FORCE, 32'h4);
            idle(3);
            chk("ch2 pin action", {31'h0, act_out[i]}, {30'h0, pin_oe[2], pin_out[2]} ^ 32'h2);
        end
        apb(1'b1, `IDX_PIN_ACTION, {30'h0, ACT_DRIVE_LOW});
        chk("ch2 disconnected", 32'h0, {31'h0, pin_oe[2]});
        $display("test pin actions done");

        // Capture on channel 1 for each edge choice, count held still
        apb(1'b1, `IDX_MAIN_COUNT, 32'h1234);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, `IDX_EDGE_SEL, {28'h0, 2'(c), 2'h0});
            apb(1'b1, `IDX_CHAN_FLAGS, 32'hF);
            ext_level[1] <= 1'b1;
            idle(3);
            apb(1'b0, `IDX_CHAN_FLAGS, 32'h0);
            chk("rise flag", c[0] ? 32'h2 : 32'h0, rd & 32'h2);
            if (c[0]) begin
                apb(1'b0, `IDX_CHAN_VALUE0 + 8'h01, 32'h0);
                chk("captured value", 32'h1234, rd);
                apb(1'b0, `IDX_CHAN_FLAGS, 32'h0);
                chk("flag fast clear", 32'h0, rd & 32'h2);
            end
            apb(1'b1, `IDX_CHAN_FLAGS, 32'hF);
            ext_level[1] <= 1'b0;
            idle(3);
            apb(1'b0, `IDX_CHAN_FLAGS, 32'h0);
            chk("fall flag", c[1] ? 32'h2 : 32'h0, rd & 32'h2);
        end
        $display("test capture done");

        // Real compare on channels 0 and 2 at 0x8000; a zero write keeps flags
        apb(1'b1, `IDX_PIN_ACTION, {26'h0, ACT_DRIVE_HIGH, 2'h0, ACT_DRIVE_LOW});
        apb(1'b1, `IDX_MAIN_COUNT, 32'h7FFF);
        apb(1'b1, `IDX_CHAN_FLAGS, 32'hF);
        ticks(2);
        apb(1'b1, `IDX_CHAN_FLAGS, 32'h0);
        apb(1'b0, `IDX_CHAN_FLAGS, 32'h0);
        chk("compare flags", 32'h5, rd);
        chk("ch2 compare drive", 32'h3, {30'h0, pin_oe[2], pin_out[2]});
        apb(1'b1, `IDX_CHAN_VALUE0 + 8'h02, 32'h8000);
        apb(1'b0, `IDX_CHAN_FLAGS, 32'h0);
        chk("compare fast clear", 32'h1, rd);
        $display("test compare done");

        // Unmapped place answers with an error and reads zero
        apb(1'b0, 8'h3F, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, last_err});
        chk("unmapped data", 32'h0, rd);
        $display("test unmapped done");
        close_out();
    end
endmodule : tb
